// ### nand_host_pkg.sv
/*
 Shared constants, types and the command step table of the NAND host
 sequencer. Assumes a 200 MHz system clock and a two-die flash target.
*/
// Overview of operation
// - Two-plane erase: 60h,addr,D1h then 60h,addr,D0h
// - Two planes need different plane bits
// - Idle die may start while another busy
// - Only listed array operations are interleaved
// - Die bit identical for both plane selections
// - Program series goes before read series
// - Unload read data before next 80h
// - Per-die status via 78h with die selected
// - Never issue 70h while interleaving dies
// - After setup commands wait for array ready
// - At most four partial programs per page
// - Scrambled area programmed once per page

package nand_host_pkg;

	// ------------------------------------------------------------
	// Clock and timing
	// ------------------------------------------------------------
	localparam int CLK_MHZ = 200;
	// Strobe timing in ns, rounded up to whole cycles
	localparam int CLE_SETUP_NS = 10;
	localparam int WE_LOW_NS = 10;
	localparam int WE_HIGH_NS = 7;
	localparam int WHR_NS = 60;
	localparam int REA_NS = 16;
	localparam int REH_NS = 7;
	localparam logic [3:0] SETUP_CYC = 4'((CLE_SETUP_NS * CLK_MHZ + 999) / 1000);
	localparam logic [3:0] WE_LOW_CYC = 4'((WE_LOW_NS * CLK_MHZ + 999) / 1000);
	localparam logic [3:0] WE_HIGH_CYC = 4'((WE_HIGH_NS * CLK_MHZ + 999) / 1000);
	localparam logic [3:0] WHR_CYC = 4'((WHR_NS * CLK_MHZ + 999) / 1000);
	localparam logic [3:0] REA_CYC = 4'((REA_NS * CLK_MHZ + 999) / 1000);
	localparam logic [3:0] REH_CYC = 4'((REH_NS * CLK_MHZ + 999) / 1000);
	// Plane queue busy and poll spacing in us
	localparam int PLANE_QUEUE_US = 1;
	localparam int POLL_GAP_US = 1;
	localparam logic [7:0] PLANE_QUEUE_CYC = 8'(PLANE_QUEUE_US * CLK_MHZ);
	localparam logic [7:0] POLL_GAP_CYC = 8'(POLL_GAP_US * CLK_MHZ);
	// Erase limits in ms
	localparam int ERASE_MS = 6;
	localparam int ERASE2_MS = 7;
	localparam int ERASE_MAX_CYC = ERASE_MS * 1000 * CLK_MHZ;
	localparam int ERASE2_MAX_CYC = ERASE2_MS * 1000 * CLK_MHZ;

	// ------------------------------------------------------------
	// Opcodes and status bits
	// ------------------------------------------------------------
	localparam logic [7:0] CMD_ERASE_SETUP = 8'h60;
	localparam logic [7:0] CMD_ERASE_QUEUE = 8'hd1;
	localparam logic [7:0] CMD_ERASE_GO = 8'hd0;
	localparam logic [7:0] CMD_RESET = 8'hff;
	localparam logic [7:0] CMD_DIE_STATUS = 8'h78;
	localparam int CACHE_READY_BIT = 6;
	localparam int ARRAY_READY_BIT = 5;
	localparam int PLANE_BIT = 6;
	localparam logic [7:0] RESET_STATUS = 8'h00;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {OP_ERASE, OP_ERASE2, OP_RESET, OP_STATUS} op_type;
	typedef enum logic [2:0] {K_CMD, K_ADDR, K_READ, K_QUEUE, K_END} kind_type;

	typedef struct packed {
		op_type op;
		logic die;
		logic [10:0] block_a;
		logic [10:0] block_b;
	} req_type;

	typedef struct packed {
		logic [1:0] ce_n;
		logic cle;
		logic ale;
		logic we_n;
		logic re_n;
		logic [7:0] dq;
		logic dq_drive_n;
	} nand_pins_type;

	typedef struct packed {
		kind_type kind;
		logic [7:0] data;
	} step_type;

	localparam nand_pins_type PINS_IDLE = '{ce_n: 2'h3, cle: 1'b0, ale: 1'b0,
		we_n: 1'b1, re_n: 1'b1, dq: 8'h00, dq_drive_n: 1'b1};

	// ------------------------------------------------------------
	// Step table
	// ------------------------------------------------------------
	// Row address byte for address cycle 1..3
	function automatic logic [7:0] row_byte(logic [17:0] r, logic [3:0] i);
		if (i == 4'h1)
			return r[7:0];
		else if (i == 4'h2)
			return r[15:8];
		else
			return {6'h00, r[17:16]};
	endfunction

	// One bus step of an operation
	// No program or page read is ever issued, so none is mixed or repeated
	function automatic step_type step_of(op_type op, logic [3:0] idx, logic [17:0] ra,
		logic [17:0] rb);
		step_type s;
		s = '{kind: K_END, data: 8'h00};
		case (op)
			OP_ERASE:
			begin
				if (idx == 4'h0) s = '{K_CMD, CMD_ERASE_SETUP};
				else if (idx < 4'h4) s = '{K_ADDR, row_byte(ra, idx)};
				else if (idx == 4'h4) s = '{K_CMD, CMD_ERASE_GO};
			end
			OP_ERASE2:
			begin
				if (idx == 4'h0) s = '{K_CMD, CMD_ERASE_SETUP};
				else if (idx < 4'h4) s = '{K_ADDR, row_byte(ra, idx)};
				else if (idx == 4'h4) s = '{K_CMD, CMD_ERASE_QUEUE};
				else if (idx == 4'h5) s = '{K_QUEUE, 8'h00};
				else if (idx == 4'h6) s = '{K_CMD, CMD_ERASE_SETUP};
				else if (idx < 4'ha) s = '{K_ADDR, row_byte(rb, idx - 4'h6)};
				else if (idx == 4'ha) s = '{K_CMD, CMD_ERASE_GO};
			end
			OP_RESET:
			begin
				if (idx == 4'h0) s = '{K_CMD, CMD_RESET};
			end
			default:
			begin
				if (idx == 4'h0) s = '{K_CMD, CMD_DIE_STATUS};
				else if (idx < 4'h4) s = '{K_ADDR, row_byte(ra, idx)};
				else if (idx == 4'h4) s = '{K_READ, 8'h00};
			end
		endcase
		return s;
	endfunction

endpackage

// ### nand_wait_timer.sv
/*
 Loadable down counter used for busy waits and time-outs.
 Assumes a synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none

module nand_wait_timer #(
	parameter int W = 8
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic load_i,
	input wire logic [W-1:0] value_i,
	output logic expired_o
);
	// ------------------------------------------------------------
	// Counter
	// ------------------------------------------------------------
	logic [W-1:0] cnt_r; // Cycles left

	// Load wins, else count to zero
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			cnt_r <= '0;
		else if (load_i)
			cnt_r <= value_i;
		else if (cnt_r != '0)
			cnt_r <= cnt_r - 1'b1;
	end

	assign expired_o = (cnt_r == '0);

endmodule

`default_nettype wire

// ### nand_bus_cycle.sv
/*
 One command, address or read cycle on the asynchronous NAND pins.
 Assumes a 200 MHz clock; data input is sampled synchronously.
*/
`timescale 1ns/1ps
`default_nettype none

module nand_bus_cycle (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic start_i,
	input wire nand_host_pkg::kind_type kind_i,
	input wire logic [7:0] byte_i,
	input wire logic die_i,
	input wire logic session_i,
	input wire logic [7:0] dq_i,
	output logic done_o,
	output logic [7:0] rdata_o,
	output nand_host_pkg::nand_pins_type pins_o
);
	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef enum logic [1:0] {E_IDLE, E_SETUP, E_STROBE, E_HOLD} eng_state_type;
	eng_state_type state_r, state_nxt; // Phase of the cycle
	logic [3:0] cnt_r, cnt_nxt; // Cycles left in phase
	logic read_r, read_nxt; // Cycle is a data read
	logic done_nxt;
	logic [7:0] rdata_nxt;
	nand_host_pkg::nand_pins_type pins_nxt;
	wire logic [1:0] ce_mask = die_i ? 2'h2 : 2'h1; // Chip enable of selected die
	wire logic phase_end = (cnt_r == 4'h1);

	// ------------------------------------------------------------
	// Phase sequencing
	// ------------------------------------------------------------
	always_comb
	begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		read_nxt = read_r;
		done_nxt = 1'b0;
		rdata_nxt = rdata_o;
		pins_nxt = pins_o;
		pins_nxt.ce_n = session_i ? ~ce_mask : 2'h3;
		case (state_r)
			E_IDLE:
			begin
				// Latch CLE/ALE and data, strobe comes after setup
				if (start_i)
				begin
					state_nxt = E_SETUP;
					read_nxt = (kind_i == nand_host_pkg::K_READ);
					cnt_nxt = read_nxt ? nand_host_pkg::WHR_CYC : nand_host_pkg::SETUP_CYC;
					pins_nxt.cle = (kind_i == nand_host_pkg::K_CMD);
					pins_nxt.ale = (kind_i == nand_host_pkg::K_ADDR);
					pins_nxt.dq = byte_i;
					pins_nxt.dq_drive_n = read_nxt;
				end
			end
			E_SETUP:
			begin
				// Open the write or read strobe
				if (phase_end)
				begin
					state_nxt = E_STROBE;
					cnt_nxt = read_r ? nand_host_pkg::REA_CYC : nand_host_pkg::WE_LOW_CYC;
					pins_nxt.re_n = ~read_r;
					pins_nxt.we_n = read_r;
				end
				else
					cnt_nxt = cnt_r - 4'h1;
			end
			E_STROBE:
			begin
				// Close the strobe; read data is valid here
				if (phase_end)
				begin
					state_nxt = E_HOLD;
					cnt_nxt = read_r ? nand_host_pkg::REH_CYC : nand_host_pkg::WE_HIGH_CYC;
					if (read_r)
						rdata_nxt = dq_i;
					pins_nxt.re_n = 1'b1;
					pins_nxt.we_n = 1'b1;
				end
				else
					cnt_nxt = cnt_r - 4'h1;
			end
			E_HOLD:
			begin
				// Hold then release the bus
				if (phase_end)
				begin
					state_nxt = E_IDLE;
					done_nxt = 1'b1;
					pins_nxt.cle = 1'b0;
					pins_nxt.ale = 1'b0;
					pins_nxt.dq_drive_n = 1'b1;
				end
				else
					cnt_nxt = cnt_r - 4'h1;
			end
			default:
				state_nxt = E_IDLE;
		endcase
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			state_r <= E_IDLE;
			cnt_r <= 4'h0;
			read_r <= 1'b0;
			done_o <= 1'b0;
			rdata_o <= 8'h00;
			pins_o <= nand_host_pkg::PINS_IDLE;
		end
		else
		begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			read_r <= read_nxt;
			done_o <= done_nxt;
			rdata_o <= rdata_nxt;
			pins_o <= pins_nxt;
		end
	end

endmodule

`default_nettype wire

// ### nand_interleave_host.sv
/*
 Host sequencer for erase, two-plane erase, reset and per-die status on
 a two-die NAND target. Tracks each die's busy state and polls the
 selected die with the enhanced status read before an erase reuses it.
 Assumes all inputs are synchronous to clk_i and the flash pins are
 joined to the target by the surrounding logic.
*/
`timescale 1ns/1ps
`default_nettype none

module nand_interleave_host #(
	parameter int TW = 21,
	parameter int ERASE_MAX_CYC = nand_host_pkg::ERASE_MAX_CYC,
	parameter int ERASE2_MAX_CYC = nand_host_pkg::ERASE2_MAX_CYC
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic req_valid_i,
	input wire nand_host_pkg::req_type req_i,
	input wire logic [7:0] dq_i,
	input wire logic rb_n_i,
	output logic req_ready_o,
	output logic done_o,
	output logic error_o,
	output logic [7:0] status_o,
	output logic [1:0] die_busy_o,
	output logic all_ready_o,
	output nand_host_pkg::nand_pins_type pins_o
);
	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	typedef enum logic [2:0] {S_IDLE, S_CHECK, S_STEP, S_WAIT, S_QUEUE, S_GAP} seq_state_type;

	seq_state_type state_r, state_nxt; // Sequencer state
	nand_host_pkg::req_type pend_r, pend_nxt; // Request in progress
	nand_host_pkg::op_type cur_op_r, cur_op_nxt; // Operation on the bus
	logic [3:0] step_r, step_nxt; // Step index within operation
	logic precheck_r, precheck_nxt; // Status poll guards a pending op
	logic poll_die_r, poll_die_nxt; // Die addressed by status read
	logic [1:0] busy_r, busy_nxt; // Die has array work running
	logic [1:0] two_r, two_nxt; // Die's last erase was two-plane
	logic blocked_r, blocked_nxt; // Setup command awaits array ready
	logic blocked_die_r, blocked_die_nxt; // Die that got the setup command
	logic [7:0] sr_nxt; // Last status byte
	logic start_r, start_nxt; // Start pulse to bus engine
	logic ready_nxt;
	logic done_nxt;
	logic err_nxt;
	logic tmo_load; // Start time-out
	logic gap_load; // Start short wait
	logic [7:0] gap_value;

	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	// Engine and timer outputs
	wire logic eng_done;
	wire logic [7:0] eng_rdata;
	wire logic gap_exp;
	wire logic tmo_exp;
	// Row address: die, block, page zero
	wire logic op_die = (cur_op_r == nand_host_pkg::OP_STATUS) ? poll_die_r : pend_r.die;
	wire logic [17:0] row_a = {op_die, pend_r.block_a, 6'h00};
	wire logic [17:0] row_b = {pend_r.die, pend_r.block_b, 6'h00};
	wire nand_host_pkg::step_type step = nand_host_pkg::step_of(cur_op_r, step_r, row_a, row_b);
	// Array operations that must find their die ready
	wire logic pend_array = (pend_r.op == nand_host_pkg::OP_ERASE) ||
		(pend_r.op == nand_host_pkg::OP_ERASE2);
	// Die to poll before issuing the pending op
	wire logic check_die = blocked_r ? blocked_die_r : pend_r.die;
	wire logic need_poll = pend_array && (blocked_r || busy_r[pend_r.die]);
	// Plane bits of a two-plane request must differ
	wire logic plane_clash = (req_i.op == nand_host_pkg::OP_ERASE2) &&
		(req_i.block_a[0] == req_i.block_b[0]);
	// Time-out length follows the die's last erase kind
	wire logic [TW-1:0] tmo_value = two_r[check_die] ? TW'(ERASE2_MAX_CYC) : TW'(ERASE_MAX_CYC);
	// Array-ready flag of the byte just read
	wire logic sr_ready = status_o[nand_host_pkg::ARRAY_READY_BIT];
	wire logic session = (state_nxt == S_STEP) || (state_nxt == S_WAIT) || (state_nxt == S_QUEUE);

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	always_comb
	begin
		state_nxt = state_r;
		pend_nxt = pend_r;
		cur_op_nxt = cur_op_r;
		step_nxt = step_r;
		precheck_nxt = precheck_r;
		poll_die_nxt = poll_die_r;
		busy_nxt = busy_r;
		two_nxt = two_r;
		blocked_nxt = blocked_r;
		blocked_die_nxt = blocked_die_r;
		sr_nxt = status_o;
		start_nxt = 1'b0;
		done_nxt = 1'b0;
		err_nxt = 1'b0;
		tmo_load = 1'b0;
		gap_load = 1'b0;
		gap_value = nand_host_pkg::POLL_GAP_CYC;
		case (state_r)
			S_IDLE:
			begin
				// Take a request; a bad plane pair is refused at once
				if (req_valid_i && req_ready_o)
				begin
					if (plane_clash)
					begin
						err_nxt = 1'b1;
						done_nxt = 1'b1;
					end
					else
					begin
						pend_nxt = req_i;
						state_nxt = S_CHECK;
					end
				end
			end
			S_CHECK:
			begin
				// Poll first if the die or a setup command is pending
				step_nxt = 4'h0;
				state_nxt = S_STEP;
				if (need_poll)
				begin
					cur_op_nxt = nand_host_pkg::OP_STATUS;
					poll_die_nxt = check_die;
					precheck_nxt = 1'b1;
					tmo_load = 1'b1;
				end
				else
				begin
					// Other die may be busy: overlap is allowed
					cur_op_nxt = pend_r.op;
					poll_die_nxt = pend_r.die;
					precheck_nxt = 1'b0;
				end
			end
			S_STEP:
			begin
				case (step.kind)
					nand_host_pkg::K_QUEUE:
					begin
						// Plane queue busy before second plane
						gap_load = 1'b1;
						gap_value = nand_host_pkg::PLANE_QUEUE_CYC;
						state_nxt = S_QUEUE;
					end
					nand_host_pkg::K_END:
					begin
						if (cur_op_r == nand_host_pkg::OP_STATUS)
						begin
							// Ready die: clear its busy and its own block
							if (sr_ready)
							begin
								busy_nxt[poll_die_r] = 1'b0;
								if (blocked_die_r == poll_die_r)
									blocked_nxt = 1'b0;
							end
							if (!precheck_r)
							begin
								done_nxt = 1'b1;
								state_nxt = S_IDLE;
							end
							else if (sr_ready)
								state_nxt = S_CHECK;
							else if (tmo_exp)
							begin
								err_nxt = 1'b1;
								done_nxt = 1'b1;
								state_nxt = S_IDLE;
							end
							else
							begin
								gap_load = 1'b1;
								state_nxt = S_GAP;
							end
						end
						else
						begin
							// Launched: die now busy
							busy_nxt[pend_r.die] = 1'b1;
							if (cur_op_r == nand_host_pkg::OP_RESET)
							begin
								blocked_nxt = 1'b1;
								blocked_die_nxt = pend_r.die;
							end
							else
								two_nxt[pend_r.die] = (cur_op_r == nand_host_pkg::OP_ERASE2);
							done_nxt = 1'b1;
							state_nxt = S_IDLE;
						end
					end
					default:
					begin
						// Command, address or read cycle
						start_nxt = 1'b1;
						state_nxt = S_WAIT;
					end
				endcase
			end
			S_WAIT:
			begin
				// Wait for the bus cycle to finish
				if (eng_done)
				begin
					if (step.kind == nand_host_pkg::K_READ)
						sr_nxt = eng_rdata;
					step_nxt = step_r + 4'h1;
					state_nxt = S_STEP;
				end
			end
			S_QUEUE:
			begin
				// Second plane follows after the queue wait
				if (gap_exp)
				begin
					step_nxt = step_r + 4'h1;
					state_nxt = S_STEP;
				end
			end
			S_GAP:
			begin
				// Space successive status polls
				if (gap_exp)
				begin
					step_nxt = 4'h0;
					state_nxt = S_STEP;
				end
			end
			default:
				state_nxt = S_IDLE;
		endcase
		ready_nxt = (state_nxt == S_IDLE);
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			state_r <= S_IDLE;
			pend_r <= '0;
			cur_op_r <= nand_host_pkg::OP_STATUS;
			step_r <= 4'h0;
			precheck_r <= 1'b0;
			poll_die_r <= 1'b0;
			two_r <= 2'h0;
			blocked_r <= 1'b0;
			blocked_die_r <= 1'b0;
			start_r <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			pend_r <= pend_nxt;
			cur_op_r <= cur_op_nxt;
			step_r <= step_nxt;
			precheck_r <= precheck_nxt;
			poll_die_r <= poll_die_nxt;
			two_r <= two_nxt;
			blocked_r <= blocked_nxt;
			blocked_die_r <= blocked_die_nxt;
			start_r <= start_nxt;
		end
	end

	// Outputs, all registered
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			req_ready_o <= 1'b0;
			done_o <= 1'b0;
			error_o <= 1'b0;
			status_o <= nand_host_pkg::RESET_STATUS;
			busy_r <= 2'h0;
			all_ready_o <= 1'b0;
		end
		else
		begin
			req_ready_o <= ready_nxt;
			done_o <= done_nxt;
			error_o <= err_nxt;
			status_o <= sr_nxt;
			busy_r <= busy_nxt;
			all_ready_o <= rb_n_i;
		end
	end

	assign die_busy_o = busy_r;

	// ------------------------------------------------------------
	// Bus engine and timers
	// ------------------------------------------------------------
	// Only 78h is used for status, never 70h
	nand_bus_cycle u_cycle (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.start_i(start_r),
		.kind_i(step.kind),
		.byte_i(step.data),
		.die_i(op_die),
		.session_i(session),
		.dq_i(dq_i),
		.done_o(eng_done),
		.rdata_o(eng_rdata),
		.pins_o(pins_o)
	);

	// Plane queue wait and poll spacing
	nand_wait_timer #(.W(8)) u_gap (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.load_i(gap_load),
		.value_i(gap_value),
		.expired_o(gap_exp)
	);

	// Longest wait for a die to become ready
	nand_wait_timer #(.W(TW)) u_tmo (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.load_i(tmo_load),
		.value_i(tmo_value),
		.expired_o(tmo_exp)
	);

endmodule

`default_nettype wire

// ### nand_interleave_host_assertions.sv
/*
 Port checks of the NAND host sequencer.
 Assumes a bind to nand_interleave_host.
*/
`timescale 1ns/1ps
`default_nettype none
module nand_interleave_host_assertions (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic req_valid_i,
	input wire nand_host_pkg::req_type req_i,
	input wire logic [7:0] dq_i,
	input wire logic rb_n_i,
	input wire logic req_ready_o,
	input wire logic done_o,
	input wire logic error_o,
	input wire logic [7:0] status_o,
	input wire logic [1:0] die_busy_o,
	input wire logic all_ready_o,
	input wire nand_host_pkg::nand_pins_type pins_o
);
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	// Request taken this edge
	wire take = req_valid_i && req_ready_o;
	// Two plane selections on one plane
	wire clash = req_i.op == nand_host_pkg::OP_ERASE2 && req_i.block_a[0] == req_i.block_b[0];
	wire cmd_strobe = pins_o.cle && !pins_o.we_n;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	a_done_one_cycle: assert property (done_o |=> !done_o)
		else $error("done longer than one cycle");
	a_error_with_done: assert property (error_o |-> done_o)
		else $error("error without done");
	a_refuse_plane_clash: assert property (take && clash |=> done_o && error_o && pins_o.ce_n == 2'h3)
		else $error("plane clash not refused");
	a_ready_drops_busy: assert property (take && !clash |=> !req_ready_o [*3])
		else $error("ready while working");
	a_no_plain_status: assert property (cmd_strobe |-> pins_o.dq != 8'h70 && !pins_o.dq_drive_n)
		else $error("plain status command");
	a_one_die_selected: assert property (pins_o.ce_n != 2'h0)
		else $error("two dies selected");
	a_idle_pins_ready: assert property (req_ready_o |-> pins_o.ce_n == 2'h3 && pins_o.dq_drive_n)
		else $error("pins busy while idle");
	a_read_bus_free: assert property (!pins_o.re_n |-> pins_o.dq_drive_n && !pins_o.cle && !pins_o.ale)
		else $error("bus driven during read");
	a_busy_clear_ready: assert property ($fell(die_busy_o[0]) || $fell(die_busy_o[1]) |-> status_o[5])
		else $error("die freed without ready flag");
	a_ready_copy: assert property (!rst_i |=> all_ready_o == $past(rb_n_i))
		else $error("all ready not tracking busy line");

	c_refuse: cover property (take && clash);
	c_erase2: cover property (take && req_i.op == nand_host_pkg::OP_ERASE2 && !clash);
	c_status: cover property (take && req_i.op == nand_host_pkg::OP_STATUS);
endmodule
bind nand_interleave_host nand_interleave_host_assertions u_chk (.*);
`default_nettype wire

// ### nand_die_model.sv
/*
 Behavioural two-die flash target with a byte log.
 Assumes pins sampled on the host clock.
*/
`timescale 1ns/1ps
`default_nettype none
module nand_die_model #(
	parameter int ERASE_BUSY = 600,
	parameter int QUEUE_BUSY = 100,
	parameter int RESET_BUSY = 40
	// Program, cache, feature and protected busy kinds never start here
) (
	input wire logic clk_i,
	input wire nand_host_pkg::nand_pins_type pins_i,
	output logic [7:0] dq_o,
	output logic rb_n_o
);
	logic we_q = 1'b1;
	logic [7:0] log_r [0:511]; // Latched bytes
	int log_n = 0;
	int busy [2] = '{0, 0}; // Busy count per die
	logic [7:0] last_cmd = 8'h00;
	int addr_n = 0;
	logic sel_die = 1'b0; // Die named by last row address
	logic [7:0] dq_last = 8'h00;
	wire we_rise = pins_i.we_n && !we_q;
	wire cur = pins_i.ce_n[0]; // Die chosen by enable
	wire [7:0] stat = {1'b1, busy[sel_die] == 0, busy[sel_die] == 0, 5'h00};

	// Latch bytes, start busy periods
	always @(posedge clk_i)
	begin
		we_q <= pins_i.we_n;
		dq_last <= dq_o;
		for (int i = 0; i < 2; i++)
			if (busy[i] > 0) busy[i] <= busy[i] - 1;
		if (we_rise && (pins_i.cle || pins_i.ale))
		begin
			log_r[log_n] <= pins_i.dq;
			log_n <= log_n + 1;
		end
		if (we_rise && pins_i.cle)
		begin
			last_cmd <= pins_i.dq;
			addr_n <= 0;
			if (pins_i.dq == 8'hff) busy[cur] <= RESET_BUSY;
			if (pins_i.dq == 8'hd1) busy[cur] <= QUEUE_BUSY;
			if (pins_i.dq == 8'hd0) busy[cur] <= ERASE_BUSY;
		end
		else if (we_rise && pins_i.ale)
		begin
			addr_n <= addr_n + 1;
			if (addr_n == 2) sel_die <= pins_i.dq[1];
		end
	end

	// Only the addressed die answers, else changing junk
	always_comb
		if (!pins_i.re_n && last_cmd == 8'h78 && !pins_i.ce_n[sel_die]) dq_o = stat;
		else dq_o = ~dq_last;
	assign rb_n_o = busy[0] == 0 && busy[1] == 0;
endmodule
`default_nettype wire

// ### nand_interleave_host_tb.sv
/*
 Self-checking bench of the NAND host sequencer.
 Assumes nand_die_model as the flash target.
*/
`timescale 1ns/1ps
`default_nettype none
module nand_interleave_host_tb;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic req_valid_i = 1'b0;
	nand_host_pkg::req_type req_i = '0;
	logic [7:0] dq_i;
	logic rb_n_i;
	logic req_ready_o;
	logic done_o;
	logic error_o;
	logic [7:0] status_o;
	logic [1:0] die_busy_o;
	logic all_ready_o;
	nand_host_pkg::nand_pins_type pins_o;
	int fails = 0;
	int check_count = 0;
	logic err_seen;
	int base;

	nand_interleave_host #(.ERASE_MAX_CYC(3000), .ERASE2_MAX_CYC(4000)) DUT (.clk_i(clk_i), .rst_i(rst_i),
		.req_valid_i(req_valid_i), .req_i(req_i), .dq_i(dq_i), .rb_n_i(rb_n_i), .req_ready_o(req_ready_o),
		.done_o(done_o), .error_o(error_o), .status_o(status_o), .die_busy_o(die_busy_o),
		.all_ready_o(all_ready_o), .pins_o(pins_o));
	nand_die_model model (.clk_i(clk_i), .pins_i(pins_o), .dq_o(dq_i), .rb_n_o(rb_n_i));

	initial
		forever #2.5 clk_i = ~clk_i;

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
		check_count++;
		if (seen !== exp)
		begin
			fails++;
			$display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	// Compare logged bytes from one index on
	task automatic check_bytes(input int from, input logic [7:0] exp [$], input string what);
		for (int k = 0; k < exp.size(); k++)
			check(model.log_r[from + k], exp[k], what);
	endtask

	// One request, wait for its done pulse
	task automatic issue(input nand_host_pkg::op_type op, input logic die, input logic [10:0] a,
		input logic [10:0] b);
		int n;
		n = 0;
		base = model.log_n;
		@(negedge clk_i);
		req_i = '{op: op, die: die, block_a: a, block_b: b};
		req_valid_i = 1'b1;
		@(negedge clk_i);
		req_valid_i = 1'b0;
		while (done_o !== 1'b1 && n < 20000)
		begin
			@(negedge clk_i);
			n++;
		end
		err_seen = error_o;
		if (n >= 20000)
		begin
			fails++;
			$display("unexpected at %0t: no done", $time);
		end
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic test_reset_poll();
		check(status_o, 8'h00, "status after reset");
		issue(nand_host_pkg::OP_RESET, 1'b0, 11'h000, 11'h000);
		check(model.log_r[base], 8'hff, "reset code");
		check(8'(die_busy_o), 8'h01, "busy after reset");
		repeat (60) @(negedge clk_i);
		issue(nand_host_pkg::OP_STATUS, 1'b0, 11'h000, 11'h000);
		check(model.log_r[base], 8'h78, "die status code");
		check(8'(status_o[5]), 8'h01, "array ready");
		check(8'(die_busy_o), 8'h00, "busy cleared");
		$display("test reset_poll ended");
	endtask

	task automatic test_refuse();
		issue(nand_host_pkg::OP_ERASE2, 1'b0, 11'h004, 11'h006);
		check(8'(err_seen), 8'h01, "clash refused");
		check(8'(model.log_n), 8'(base), "no bytes on refusal");
		$display("test refuse ended");
	endtask

	task automatic test_two_plane();
		issue(nand_host_pkg::OP_ERASE2, 1'b0, 11'h012, 11'h013);
		check(8'(err_seen), 8'h00, "two plane accepted");
		check_bytes(base, '{8'h60, 8'h80, 8'h04, 8'h00, 8'hd1, 8'h60, 8'hc0, 8'h04, 8'h00, 8'hd0}, "erase2");
		repeat (2) @(negedge clk_i);
		check(8'(all_ready_o), 8'h00, "busy line low");
		$display("test two_plane ended");
	endtask

	task automatic test_interleave();
		issue(nand_host_pkg::OP_ERASE, 1'b1, 11'h7ff, 11'h000);
		check_bytes(base, '{8'h60, 8'hc0, 8'hff, 8'h03, 8'hd0}, "erase on idle die");
		check(8'(die_busy_o), 8'h03, "both dies busy");
		issue(nand_host_pkg::OP_STATUS, 1'b1, 11'h000, 11'h000);
		check(8'(status_o[5]), 8'h00, "busy die not ready");
		check(8'(status_o[6]), 8'h00, "busy die cache");
		issue(nand_host_pkg::OP_ERASE, 1'b0, 11'h002, 11'h000);
		check(model.log_r[base], 8'h78, "poll before reuse");
		check_bytes(model.log_n - 5, '{8'h60, 8'h80, 8'h00, 8'h00, 8'hd0}, "erase after poll");
		check(8'(all_ready_o), 8'h00, "busy line while busy");
		repeat (1500) @(negedge clk_i);
		issue(nand_host_pkg::OP_STATUS, 1'b1, 11'h000, 11'h000);
		check(8'(status_o[6:5]), 8'h03, "finished die flags");
		check(8'(die_busy_o), 8'h01, "only polled die freed");
		check(8'(all_ready_o), 8'h01, "busy line released");
		$display("test interleave ended");
	endtask

	// ----------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------
	initial
	begin
		repeat (12) @(posedge clk_i);
		@(negedge clk_i);
		rst_i = 1'b0;
		@(negedge clk_i);
		test_reset_poll();
		test_refuse();
		test_two_plane();
		test_interleave();
		complete_run();
	end

	initial
	begin
		repeat (40000) @(posedge clk_i);
		fails++;
		$display("unexpected at %0t: watchdog expired", $time);
		complete_run();
	end
endmodule
`default_nettype wire
